// [rtl/adc_sequencing_control.sv]
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - software-start mode plus start bit begins one conversion of selected channel.
// - completion stores result, sets end flag and raises done interrupt together.
// - start bit clears itself once conversion has begun.
// - repeat mode restarts conversion each time one completes.
// - disable code halts conversion at once; cut conversion leaves result untouched.
// - reading the upper result byte clears the end flag; a lower byte read leaves it set.
// - new start clears end flag but keeps old result until next completion.
// - standby aborts conversion, resets both control registers, result undefined.
// - after standby no conversion resumes without a fresh start.
// - standby disconnects the reference ladder.
// - each conversion yields a ten-bit unsigned code.
// - busy rises at conversion start, falls at finish, disable abort or standby.
// - time field sets length 39 to 1248 cycles, doubling; two codes reserved.
module adc_sequencing_control (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        standby,
    input  wire logic        comparator_in,
    output logic      [3:0]  channel_select_field,
    output logic             analog_input_disable,
    output logic             ladder_connect_control,
    output logic      [9:0]  dac_code,
    output logic             sample_enable,
    output logic             conversion_done_irq,
    output logic             irq
);
    conv_if cv ();

    sar_engine u_engine (
        .mclk  (mclk),
        .reset (reset),
        .cv    (cv)
    );

    logic                              pready_reg;
    logic                              pslverr_reg;
    logic [31:0]                       prdata_reg;
    logic                              start_pend_reg;
    adc_seq_pkg::op_mode_e             mode_reg;
    logic                              indis_reg;
    logic [3:0]                        chan_reg;
    logic                              ladder_on_reg;
    logic [2:0]                        time_reg;
    logic [adc_seq_pkg::RES_W-1:0]     result_reg;
    logic                              eoc_reg;
    logic [adc_seq_pkg::IRQ_W-1:0]     stat_reg;
    logic [adc_seq_pkg::IRQ_W-1:0]     stat_next;
    logic [adc_seq_pkg::IRQ_W-1:0]     en_reg;
    logic                              irq_reg;
    logic                              done_irq_reg;
    logic                              ladder_reg;
    logic                              comp_s1_reg;
    logic                              comp_s2_reg;
    logic                              setup;
    logic                              acc;
    logic                              wr;
    logic                              rd_hi;
    logic                              sw_start;
    logic                              rpt_start;
    logic                              mode_abort;

    // decode one aligned word
    function automatic logic is_reg(input logic [11:0] a, input logic [9:0] idx);
        is_reg = (a[1:0] == 2'h0) && (a[11:2] == idx);
    endfunction : is_reg

    function automatic logic mapped(input logic [11:0] a);
        mapped = is_reg(a, adc_seq_pkg::IDX_CTRL1) || is_reg(a, adc_seq_pkg::IDX_CTRL2)
              || is_reg(a, adc_seq_pkg::IDX_RES_HI) || is_reg(a, adc_seq_pkg::IDX_RES_LO)
              || is_reg(a, adc_seq_pkg::IDX_IRQ_STAT) || is_reg(a, adc_seq_pkg::IDX_IRQ_CLR)
              || is_reg(a, adc_seq_pkg::IDX_IRQ_EN);
    endfunction : mapped

    // bus phase qualifiers; a write lands only at the completing edge
    assign setup = psel && !penable;
    assign acc   = psel && penable && pready_reg;
    assign wr    = acc && pwrite && !pslverr_reg;
    assign rd_hi = acc && !pwrite && is_reg(paddr, adc_seq_pkg::IDX_RES_HI);

    // ready comes one cycle after setup, so every access has zero wait states
    always_ff @(posedge mclk) begin
        if (reset) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && !mapped(paddr);
        end
    end

    // read data captured at setup; write-only clear word reads zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            prdata_reg <= 32'h0000_0000;
            if (is_reg(paddr, adc_seq_pkg::IDX_CTRL1))
                prdata_reg[7:0] <= {start_pend_reg, mode_reg, indis_reg, chan_reg};
            if (is_reg(paddr, adc_seq_pkg::IDX_CTRL2))
                prdata_reg[7:0] <= {2'h0, ladder_on_reg, 1'b1, time_reg, 1'b0};
            if (is_reg(paddr, adc_seq_pkg::IDX_RES_HI))
                prdata_reg[7:0] <= result_reg[9:2];
            if (is_reg(paddr, adc_seq_pkg::IDX_RES_LO))
                prdata_reg[7:0] <= {result_reg[1:0], eoc_reg, cv.busy, 4'h0};
            if (is_reg(paddr, adc_seq_pkg::IDX_IRQ_STAT))
                prdata_reg[1:0] <= stat_reg;
            if (is_reg(paddr, adc_seq_pkg::IDX_IRQ_EN))
                prdata_reg[1:0] <= en_reg;
        end
    end

    // control register one; standby forces reset value and locks out writes
    always_ff @(posedge mclk) begin
        if (reset || standby) begin
            start_pend_reg <= adc_seq_pkg::CTRL1_RST[adc_seq_pkg::CR1_START];
            mode_reg       <= adc_seq_pkg::op_mode_e'(adc_seq_pkg::CTRL1_RST[6:5]);
            indis_reg      <= adc_seq_pkg::CTRL1_RST[adc_seq_pkg::CR1_INDIS];
            chan_reg       <= adc_seq_pkg::CTRL1_RST[3:0];
        end else begin
            start_pend_reg <= 1'b0;
            if (wr && is_reg(paddr, adc_seq_pkg::IDX_CTRL1)) begin
                start_pend_reg <= pwdata[adc_seq_pkg::CR1_START];
                mode_reg       <= adc_seq_pkg::op_mode_e'(pwdata[6:5]);
                indis_reg      <= pwdata[adc_seq_pkg::CR1_INDIS];
                chan_reg       <= pwdata[3:0];
            end
        end
    end

    // control register two
    always_ff @(posedge mclk) begin
        if (reset || standby) begin
            ladder_on_reg <= adc_seq_pkg::CTRL2_RST[adc_seq_pkg::CR2_LADDER];
            time_reg      <= adc_seq_pkg::CTRL2_RST[3:1];
        end else if (wr && is_reg(paddr, adc_seq_pkg::IDX_CTRL2)) begin
            ladder_on_reg <= pwdata[adc_seq_pkg::CR2_LADDER];
            time_reg      <= pwdata[3:1];
        end
    end

    // a start bit seen while busy is dropped, not queued
    assign sw_start  = start_pend_reg && !cv.busy && !standby
                    && (mode_reg == adc_seq_pkg::MODE_SOFT
                     || mode_reg == adc_seq_pkg::MODE_REPEAT);
    assign rpt_start = cv.done && !standby
                    && (mode_reg == adc_seq_pkg::MODE_REPEAT);
    assign mode_abort = cv.busy && (mode_reg == adc_seq_pkg::MODE_DISABLE);

    // engine hookup; the abort kills the cycle's result before it is stored
    assign cv.start = sw_start || rpt_start;
    assign cv.abort = mode_abort || (cv.busy && standby);
    assign cv.len   = adc_seq_pkg::conv_len(time_reg);
    assign cv.comp  = comp_s2_reg;

    // comparator comes from the analog side, so it is synchronised first
    always_ff @(posedge mclk) begin
        if (reset) begin
            comp_s1_reg <= 1'b0;
            comp_s2_reg <= 1'b0;
        end else begin
            comp_s1_reg <= comparator_in;
            comp_s2_reg <= comp_s1_reg;
        end
    end

    // result holds until the next completion; standby wipes it
    always_ff @(posedge mclk) begin
        if (reset || standby) result_reg <= '0;
        else if (cv.done) result_reg <= cv.result;
    end

    // end flag: completion wins over a clearing read in the same cycle
    always_ff @(posedge mclk) begin
        if (reset || standby) eoc_reg <= 1'b0;
        else if (cv.done) eoc_reg <= 1'b1;
        else if (rd_hi) eoc_reg <= 1'b0;
        else if (sw_start) eoc_reg <= 1'b0;
    end

    // one-cycle done pulse, also every repeat completion
    always_ff @(posedge mclk) begin
        if (reset) done_irq_reg <= 1'b0;
        else done_irq_reg <= cv.done;
    end

    // ladder follows the conversion unless held on; never in standby
    always_ff @(posedge mclk) begin
        if (reset) ladder_reg <= 1'b0;
        else ladder_reg <= !standby && (ladder_on_reg || cv.busy);
    end

    // sticky status; new events beat a clear written in the same cycle
    always_comb begin
        stat_next = stat_reg;
        if (wr && is_reg(paddr, adc_seq_pkg::IDX_IRQ_CLR))
            stat_next = stat_reg & ~pwdata[adc_seq_pkg::IRQ_W-1:0];
        if (cv.done) stat_next[adc_seq_pkg::IRQ_DONE] = 1'b1;
        if (mode_abort) stat_next[adc_seq_pkg::IRQ_ABORT] = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            stat_reg <= '0;
            en_reg   <= '0;
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            if (wr && is_reg(paddr, adc_seq_pkg::IDX_IRQ_EN))
                en_reg <= pwdata[adc_seq_pkg::IRQ_W-1:0];
            irq_reg <= |(stat_reg & en_reg);
        end
    end

    assign prdata                 = prdata_reg;
    assign pready                 = pready_reg;
    assign pslverr                = pslverr_reg;
    assign channel_select_field   = chan_reg;
    assign analog_input_disable   = indis_reg;
    assign ladder_connect_control = ladder_reg;
    assign dac_code               = cv.dac;
    assign sample_enable          = cv.sample;
    assign conversion_done_irq    = done_irq_reg;
    assign irq                    = irq_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_soft_start;
        (wr && is_reg(paddr, adc_seq_pkg::IDX_CTRL1) && pwdata[7] && pwdata[6:5] == 2'h1
         && !cv.busy && !standby) |=> ##1 (cv.busy || $past(standby));
    endproperty
    a_soft_start: assert property (p_soft_start)
        else $error("software start did not begin a conversion");

    property p_done_together;
        cv.done && !standby |=> eoc_reg && conversion_done_irq
                             && result_reg == $past(cv.result);
    endproperty
    a_done_together: assert property (p_done_together)
        else $error("completion effects not simultaneous");

    property p_start_self_clear;
        $rose(cv.busy) |-> !start_pend_reg;
    endproperty
    a_start_self_clear: assert property (p_start_self_clear)
        else $error("start bit still set after conversion began");

    property p_repeat;
        rpt_start |=> cv.busy [*3];
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("repeat mode did not restart");

    property p_abort_keeps;
        mode_abort && !standby |=> !cv.busy && $stable(result_reg) ##1 $stable(result_reg);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps)
        else $error("disabled conversion continued or stored a result");

    property p_read_clears;
        rd_hi && !cv.done |=> !eoc_reg;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("result read left end flag set");

    property p_restart_keeps;
        sw_start && !cv.done |=> !eoc_reg && $stable(result_reg);
    endproperty
    a_restart_keeps: assert property (p_restart_keeps)
        else $error("restart changed end flag or old result");

    property p_standby;
        standby |=> !cv.busy && mode_reg == adc_seq_pkg::MODE_DISABLE && chan_reg == 4'h0
                 && time_reg == 3'h0 && !ladder_connect_control;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby did not reset the converter");

    property p_no_resume;
        $fell(standby) |-> !cv.busy ##1 !cv.busy;
    endproperty
    a_no_resume: assert property (p_no_resume)
        else $error("conversion resumed after standby");

    property p_busy_falls;
        cv.done |-> !cv.busy ##1 (cv.busy == $past(rpt_start));
    endproperty
    a_busy_falls: assert property (p_busy_falls)
        else $error("busy flag wrong around completion");

    property p_irq_pulse;
        conversion_done_irq |=> !conversion_done_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("done interrupt longer than one cycle");

    property p_abort_flag;
        mode_abort |=> stat_reg[adc_seq_pkg::IRQ_ABORT];
    endproperty
    a_abort_flag: assert property (p_abort_flag)
        else $error("disable in mid conversion left no abort status");

    property p_irq_level;
        irq == $past(|(stat_reg & en_reg));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt line does not follow enabled status");

    // cycles since the last engine start, saturating; keeps the covers free of long ranges
    logic [adc_seq_pkg::LEN_W-1:0]     since_start_reg;
    logic                              soft_run_reg;

    always_ff @(posedge mclk) begin
        if (reset || cv.start) since_start_reg <= '0;
        else if (since_start_reg != '1) since_start_reg <= since_start_reg + 11'h001;
    end

    // remembers whether the running conversion came from software or from repeat
    always_ff @(posedge mclk) begin
        if (reset) soft_run_reg <= 1'b0;
        else if (cv.start) soft_run_reg <= sw_start;
    end

    c_soft_done: cover property (cv.done && soft_run_reg
                                 && since_start_reg <= adc_seq_pkg::conv_len(3'h6));
    c_repeat: cover property (cv.done && !soft_run_reg
                              && since_start_reg <= adc_seq_pkg::conv_len(3'h6));
    c_mode_abort: cover property (mode_abort);
    c_standby_busy: cover property (cv.busy && standby);
endmodule : adc_sequencing_control
`default_nettype wire

// [rtl/adc_seq_pkg.sv]
package adc_seq_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL1    = 10'h00E;
    localparam logic [9:0] IDX_CTRL2    = 10'h00F;
    localparam logic [9:0] IDX_RES_HI   = 10'h020;
    localparam logic [9:0] IDX_RES_LO   = 10'h021;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h030;
    localparam logic [9:0] IDX_IRQ_CLR  = 10'h031;
    localparam logic [9:0] IDX_IRQ_EN   = 10'h032;

    // control register one fields
    localparam int CR1_START    = 7;
    localparam int CR1_MODE_LSB = 5;
    localparam int CR1_INDIS    = 4;
    localparam int CR1_CH_LSB   = 0;
    // control register two fields
    localparam int CR2_LADDER   = 5;
    localparam int CR2_TIME_LSB = 1;
    // result lower / status register fields
    localparam int RL_EOC       = 5;
    localparam int RL_BUSY      = 4;

    localparam logic [7:0] CTRL1_RST = 8'h10;
    localparam logic [7:0] CTRL2_RST = 8'h10;

    // interrupt status bits
    localparam int IRQ_W     = 2;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ABORT = 1;

    localparam int RES_W = 10;
    localparam int LEN_W = 11;
    // ten bit trials of three cycles each close every conversion
    localparam logic [LEN_W-1:0] SETTLE_CYC = 11'h01E;
    localparam logic [1:0]       TRIAL_LAST = 2'h2;
    localparam logic [RES_W-1:0] MSB_MASK   = 10'h200;

    typedef enum logic [1:0] {
        MODE_DISABLE = 2'h0,
        MODE_SOFT    = 2'h1,
        MODE_RSVD    = 2'h2,
        MODE_REPEAT  = 2'h3
    } op_mode_e;

    // conversion length in core clock cycles per time code
    function automatic logic [LEN_W-1:0] conv_len(input logic [2:0] code);
        case (code)
            3'h0:    conv_len = 11'h027;
            3'h2:    conv_len = 11'h04E;
            3'h3:    conv_len = 11'h09C;
            3'h4:    conv_len = 11'h138;
            3'h5:    conv_len = 11'h270;
            default: conv_len = 11'h4E0;
        endcase
    endfunction : conv_len
endpackage : adc_seq_pkg

// [rtl/conv_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
    logic                             start;
    logic                             abort;
    logic [adc_seq_pkg::LEN_W-1:0]    len;
    logic                             comp;
    logic                             busy;
    logic                             done;
    logic [adc_seq_pkg::RES_W-1:0]    result;
    logic [adc_seq_pkg::RES_W-1:0]    dac;
    logic                             sample;

    modport ctl (output start, abort, len, comp, input busy, done, result, dac, sample);
    modport eng (input start, abort, len, comp, output busy, done, result, dac, sample);
endinterface : conv_if
`default_nettype wire

// [rtl/sar_engine.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
    input  wire logic mclk,
    input  wire logic reset,
    conv_if.eng       cv
);
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_TRIAL  = 2'b11
    } eng_state_e;

    eng_state_e                     state_reg;
    logic [adc_seq_pkg::LEN_W-1:0]  cnt_reg;
    logic [adc_seq_pkg::LEN_W-1:0]  len_reg;
    logic [1:0]                     sub_reg;
    logic [adc_seq_pkg::RES_W-1:0]  mask_reg;
    logic [adc_seq_pkg::RES_W-1:0]  code_reg;
    logic [adc_seq_pkg::RES_W-1:0]  result_reg;
    logic [adc_seq_pkg::RES_W-1:0]  decided;
    logic                           busy_reg;
    logic                           done_reg;
    logic                           sample_reg;

    // comparator high keeps the trial bit, low drops it
    assign decided = cv.comp ? code_reg : (code_reg & ~mask_reg);

    // sample phase, then one 3-cycle trial per bit, msb first
    always_ff @(posedge mclk) begin
        done_reg <= 1'b0;
        if (reset || cv.abort) begin
            state_reg  <= ST_IDLE;
            busy_reg   <= 1'b0;
            sample_reg <= 1'b0;
            cnt_reg    <= '0;
            len_reg    <= '0;
            sub_reg    <= '0;
            mask_reg   <= '0;
            code_reg   <= '0;
            if (reset) result_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cv.start) begin
                        state_reg  <= ST_SAMPLE;
                        busy_reg   <= 1'b1;
                        sample_reg <= 1'b1;
                        cnt_reg    <= '0;
                        len_reg    <= cv.len;
                        code_reg   <= '0;
                    end
                end
                ST_SAMPLE: begin
                    cnt_reg <= cnt_reg + 11'h001;
                    if (cnt_reg == len_reg - adc_seq_pkg::SETTLE_CYC - 11'h001) begin
                        state_reg  <= ST_TRIAL;
                        sample_reg <= 1'b0;
                        mask_reg   <= adc_seq_pkg::MSB_MASK;
                        code_reg   <= adc_seq_pkg::MSB_MASK;
                        sub_reg    <= '0;
                    end
                end
                ST_TRIAL: begin
                    cnt_reg <= cnt_reg + 11'h001;
                    sub_reg <= sub_reg + 2'h1;
                    if (sub_reg == adc_seq_pkg::TRIAL_LAST) begin
                        sub_reg <= '0;
                        if (mask_reg[0]) begin
                            // last bit decided: ten-bit unsigned code out
                            state_reg  <= ST_IDLE;
                            busy_reg   <= 1'b0;
                            done_reg   <= 1'b1;
                            result_reg <= decided;
                            code_reg   <= decided;
                        end else begin
                            code_reg <= decided | (mask_reg >> 1);
                            mask_reg <= mask_reg >> 1;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign cv.busy   = busy_reg;
    assign cv.done   = done_reg;
    assign cv.result = result_reg;
    assign cv.dac    = code_reg;
    assign cv.sample = sample_reg;

    // busy cycles counted for the length check
    logic [adc_seq_pkg::LEN_W-1:0] busy_cyc;
    always_ff @(posedge mclk) begin
        if (reset || !busy_reg) busy_cyc <= '0;
        else busy_cyc <= busy_cyc + 11'h001;
    end

    property p_conv_length;
        @(posedge mclk) disable iff (reset)
        done_reg |-> (busy_cyc == len_reg);
    endproperty
    a_conv_length: assert property (p_conv_length)
        else $error("conversion length differs from selected time");
endmodule : sar_engine
`default_nettype wire

// [dv/comparator_model.sv]
`timescale 1ns/1ps
`default_nettype none
// analog comparator stand-in; half an lsb offset keeps a trial equal to the input
module comparator_model (
    input  wire logic [9:0] dac_code,
    input  wire logic [9:0] vin,
    output logic            comparator_in
);
    // settles at once like the analog part; a register here would outrun the 3-cycle trial
    assign comparator_in = ({vin, 1'b1} > {dac_code, 1'b0});
endmodule : comparator_model
`default_nettype wire

// [dv/adc_sequencing_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_sequencing_control_tb;
    localparam logic [11:0] C1 = 12'h038, C2 = 12'h03C, HI = 12'h080, LO = 12'h084;
    localparam logic [11:0] ST = 12'h0C0, CL = 12'h0C4, EN = 12'h0C8;
    logic        mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        standby = 1'b0, cmp, done, irq, ladder, pready, pslverr, err, indis, smp;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h00008C5C;
    logic [9:0]  dac, vin = 10'h000, old;
    logic [3:0]  ch = 4'h0, chan;
    int          errors = 0, check_count = 0, cyc = 0, te, ts, n;

    always #10 mclk = ~mclk;
    // edge counter; non-blocking, so a read on an edge sees the count before that edge
    always @(posedge mclk) cyc <= cyc + 1;

    adc_sequencing_control uut (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby(standby), .comparator_in(cmp),
        .channel_select_field(chan), .analog_input_disable(indis), .ladder_connect_control(ladder),
        .dac_code(dac), .sample_enable(smp), .conversion_done_irq(done), .irq(irq));

    comparator_model cmp_m (.dac_code(dac), .vin(vin), .comparator_in(cmp));

    // xorshift generator; the fixed seed keeps every run the same
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // conversion length per time code; reserved codes run the longest length
    function automatic int clen(input logic [2:0] t);
        return (t == 3'h0) ? 39 : (t == 3'h1 || t == 3'h7) ? 1248 : 39 << (t - 1);
    endfunction : clen

    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        check_count++;
        if (a !== e) begin
            errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : chk

    // one apb transfer; held until pready, te is the edge where it takes effect
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        te = cyc + 1;
        psel <= 1'b0;
        penable <= 1'b0;
        // return off the edge so callers never look at outputs mid-update
        @(negedge mclk);
    endtask : bus

    // set up fully, start bit last; callers only restart once the end is seen
    task automatic start(input logic [1:0] m, input logic [2:0] t);
        seed = xorshift(seed);
        vin = seed[9:0];
        ch = {1'b0, seed[12:10]};
        bus(1'b1, C2, {28'h1, t, 1'b0});
        bus(1'b1, C1, {24'h0, 1'b1, m, 1'b0, ch});
        ts = te;
    endtask : start

    // n is edges from ts to the done pulse; gives up after lim edges
    task automatic wait_done(input int lim);
        do @(negedge mclk); while (done !== 1'b1 && cyc - ts < lim);
        n = cyc - ts;
    endtask : wait_done

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // main sequence
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        bus(1'b0, C1, 32'h0);
        chk(32'h10, rd);
        bus(1'b0, C2, 32'h0);
        chk(32'h10, rd);
        bus(1'b0, 12'h100, 32'h0);
        chk(32'h1, 32'(err));
        // every time code with the done interrupt masked on even codes
        for (int t = 0; t < 8; t++) begin
            bus(1'b1, EN, {31'h0, t[0]});
            start(2'h1, t[2:0]);
            chk(32'(ch), 32'(chan));
            chk(32'h0, 32'(indis));
            bus(1'b0, C1, 32'h0);
            chk(32'h20 | 32'(ch), rd);
            bus(1'b0, LO, 32'h0);
            chk(32'h10, rd & 32'h30);
            chk(32'h1, 32'(smp));
            wait_done(3000);
            chk(32'(clen(t[2:0]) + 2), 32'(n));
            @(negedge mclk);
            chk(32'h0, 32'(done));
            bus(1'b0, LO, 32'h0);
            chk({24'h0, vin[1:0], 6'h20}, rd);
            bus(1'b0, HI, 32'h0);
            chk({24'h0, vin[9:2]}, rd);
            bus(1'b0, LO, 32'h0);
            chk({24'h0, vin[1:0], 6'h00}, rd);
            chk(32'(t[0]), 32'(irq));
            bus(1'b1, CL, 32'h3);
            bus(1'b0, ST, 32'h0);
            chk(32'h0, rd | 32'(irq));
        end
        // restart before the result is read
        start(2'h1, 3'h0);
        wait_done(3000);
        old = vin;
        start(2'h1, 3'h0);
        bus(1'b0, LO, 32'h0);
        chk({24'h0, old[1:0], 6'h10}, rd);
        bus(1'b0, HI, 32'h0);
        chk({24'h0, old[9:2]}, rd);
        wait_done(3000);
        bus(1'b0, HI, 32'h0);
        chk({24'h0, vin[9:2]}, rd);
        // repeat mode, then disable in mid conversion with a new input
        start(2'h3, 3'h0);
        wait_done(3000);
        ts = cyc;
        wait_done(3000);
        chk(32'h28, 32'(n));
        old = vin;
        vin = ~vin;
        bus(1'b1, C1, {28'h0, ch});
        ts = te;
        wait_done(60);
        chk(32'h0, 32'(done));
        bus(1'b0, HI, 32'h0);
        chk({24'h0, old[9:2]}, rd);
        // standby in mid conversion; the start written meanwhile must be dropped
        start(2'h1, 3'h6);
        repeat (50) @(posedge mclk);
        standby <= 1'b1;
        bus(1'b1, C1, 32'hA0);
        chk(32'h0, 32'(ladder));
        @(posedge mclk);
        standby <= 1'b0;
        bus(1'b0, C1, 32'h0);
        chk(32'h10, rd);
        chk(32'h1, 32'(indis));
        bus(1'b0, LO, 32'h0);
        chk(32'h0, rd & 32'h30);
        ts = cyc;
        wait_done(1300);
        chk(32'h0, 32'(done));
        give_verdict();
    end

    // watchdog at about six times the planned run
    initial begin
        #800000;
        errors++;
        give_verdict();
    end
endmodule : adc_sequencing_control_tb
`default_nettype wire
